// *** rtl/otp_defs.svh ***
`ifndef OTP_DEFS_SVH
`define OTP_DEFS_SVH

// address and data widths
`define ADDR_LOW_W 8
`define ADDR_HIGH_W 7
`define CODE_ADDR_W 15
`define CODE_DEPTH 32768
`define ENC_INDEX_W 6
`define ENC_DEPTH 64
`define BYTE_W 8

// mode pin codes, bit4 down to bit0
`define MODE_VERIFY 5'h03
`define MODE_SIGNATURE 5'h00
`define MODE_PROG_CODE 5'h0F
`define MODE_PROG_ENC 5'h0D
`define MODE_PROG_LOCK 5'h1C

// strobe pulse counts per programming target
`define CODE_PULSES 5'h05
`define ENC_PULSES 5'h19
`define PULSE_CNT_W 5

// erased cell value
`define ERASED_BYTE 8'h00

// signature locations (arbitrary identity values are parameters)
`define SIG_MAKER_ADDR 15'h0030
`define SIG_PART_ADDR 15'h0060

// access timing: 48 oscillator periods, fastest oscillator 6 MHz
`define ACCESS_OSC_PERIODS 48
`define OSC_MAX_KHZ 6000
`define REF_CLK_KHZ 200000
`define ACCESS_MAX_CYC ((`ACCESS_OSC_PERIODS * `REF_CLK_KHZ) / `OSC_MAX_KHZ)
`define ACCESS_CNT_W 11

`endif

// *** rtl/otp_pkg.sv ***
package otp_pkg;

    // mode select pins as seen on the port
    typedef struct packed {
        logic mode_select_bit4;
        logic mode_select_bit3;
        logic mode_select_bit2;
        logic mode_select_bit1;
        logic mode_select_bit0;
    } mode_sel_t;

    // decoded operation
    typedef enum logic [2:0] {
        OP_IDLE,
        OP_VERIFY,
        OP_SIGNATURE,
        OP_PROG_CODE,
        OP_PROG_ENC,
        OP_PROG_LOCK
    } op_t;

endpackage : otp_pkg

// *** rtl/otp_scramble_table.sv ***
`timescale 1ns/1ps
`include "otp_defs.svh"

module otp_scramble_table (
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire logic [`ENC_INDEX_W-1:0] i_index,
    input wire logic i_we,
    input wire logic [`BYTE_W-1:0] i_wdata,
    input wire logic [`BYTE_W-1:0] i_code_byte,
    output logic [`BYTE_W-1:0] o_verify_byte
);
    // one stored entry per index
    logic [`BYTE_W-1:0] entry_r [0:`ENC_DEPTH-1];

    // entries start erased and are written by index
    genvar g;
    generate
        for (g = 0; g < `ENC_DEPTH; g++) begin : g_entry
            always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    entry_r[g] <= `ERASED_BYTE;
                end else if (i_we && (i_index == `ENC_INDEX_W'(g))) begin
                    entry_r[g] <= i_wdata;
                end
            end
        end
    endgenerate

    // no path reads entries out raw
    always_comb begin
        o_verify_byte = ~(i_code_byte ^ entry_r[i_index]);
    end

endmodule : otp_scramble_table

// *** rtl/otp_program_verify_access.sv ***
`timescale 1ns/1ps
`include "otp_defs.svh"

// Function
// - second lock bit blocks verify reads
// - verify drives addressed byte on data port
// - output is code xnor table entry
// - low six address bits pick entry
// - table contents never readable outside
// - verify and signature mode pin levels
// - programming target chosen by mode bits
// - data valid within 48 periods of address
// - data valid/released within 48 periods
// - blank byte through blank entry reads back as FFh
// - five strobe pulses program code byte
// - twenty-five pulses for table or lock
// - any lock blocks code/table programming
module otp_program_verify_access #(
    parameter logic [7:0] SIG_MAKER_VALUE = 8'hA5, // arbitrary value
    parameter logic [7:0] SIG_PART_VALUE = 8'h5A // arbitrary value
) (
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire logic i_device_reset,
    input wire logic [`ADDR_LOW_W-1:0] i_address_low_port,
    input wire logic [`ADDR_HIGH_W-1:0] i_address_high_port,
    input wire logic [`BYTE_W-1:0] i_byte_data_port,
    output logic [`BYTE_W-1:0] o_byte_data_port,
    output logic o_byte_data_port_oe,
    input wire logic i_program_strobe_n,
    input wire logic i_program_store_pin,
    input wire otp_pkg::mode_sel_t i_mode_select,
    input wire logic i_test_enable_programming_supply,
    input wire logic i_test_enable_programming_supply_hv,
    output logic o_first_lock_bit,
    output logic o_second_lock_bit
);
    import otp_pkg::*;

    // code array, erased at power up
    logic [`BYTE_W-1:0] code_mem_r [0:`CODE_DEPTH-1];
    logic [`CODE_ADDR_W-1:0] addr; // full 15-bit address
    logic [`CODE_ADDR_W-1:0] addr_prev_r; // address one cycle ago
    logic [`BYTE_W-1:0] rd_code_r; // raw byte read from array
    logic [`BYTE_W-1:0] verify_byte; // scrambled byte
    logic [`BYTE_W-1:0] out_nxt; // next data port value
    logic read_en; // verify/signature allowed now
    logic read_en_r; // read_en one cycle ago
    op_t op; // decoded operation
    op_t op_prev_r; // operation one cycle ago
    logic strobe_prev_r; // strobe one cycle ago
    logic strobe_rise; // end of a low pulse
    logic [`PULSE_CNT_W-1:0] pulse_cnt_r; // completed low pulses
    logic [`PULSE_CNT_W-1:0] pulse_target; // pulses for current op
    logic commit; // final pulse of a sequence
    logic code_we; // code byte write
    logic enc_we; // table entry write
    logic lock_we; // lock bit write
    logic any_lock; // either lock programmed
    logic [`ACCESS_CNT_W-1:0] wait_cnt_r; // cycles waiting for data
    logic [`BYTE_W-1:0] entry_probe; // table entry behind current read, for checks only

    // address assembled from low and high ports
    assign addr = {i_address_high_port, i_address_low_port};
    assign any_lock = o_first_lock_bit || o_second_lock_bit;

    // erased contents at power up
    initial begin
        for (int i = 0; i < `CODE_DEPTH; i++) begin
            code_mem_r[i] = `ERASED_BYTE;
        end
    end

    always_comb begin
        op = OP_IDLE;
        if (i_device_reset && !i_program_store_pin) begin
            if (i_test_enable_programming_supply_hv) begin
                // programming supply present
                case (i_mode_select)
                    `MODE_PROG_CODE: op = OP_PROG_CODE;
                    `MODE_PROG_ENC: op = OP_PROG_ENC;
                    `MODE_PROG_LOCK: op = OP_PROG_LOCK;
                    default: op = OP_IDLE;
                endcase
            end else if (i_test_enable_programming_supply && i_program_strobe_n) begin
                // logic-high supply, strobe idle high
                case (i_mode_select)
                    `MODE_VERIFY: op = OP_VERIFY;
                    `MODE_SIGNATURE: op = OP_SIGNATURE;
                    default: op = OP_IDLE;
                endcase
            end
        end
    end

    // verify only while second lock clear
    assign read_en = (op == OP_SIGNATURE) || ((op == OP_VERIFY) && !o_second_lock_bit);

    // previous-cycle history of pins and decode
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            strobe_prev_r <= 1'b1;
            op_prev_r <= OP_IDLE;
            addr_prev_r <= '0;
            read_en_r <= 1'b0;
        end else begin
            strobe_prev_r <= i_program_strobe_n;
            op_prev_r <= op;
            addr_prev_r <= addr;
            read_en_r <= read_en;
        end
    end

    assign strobe_rise = i_program_strobe_n && !strobe_prev_r;

    always_comb begin
        case (op)
            OP_PROG_CODE: pulse_target = `CODE_PULSES;
            OP_PROG_ENC: pulse_target = `ENC_PULSES;
            OP_PROG_LOCK: pulse_target = `ENC_PULSES;
            default: pulse_target = `CODE_PULSES;
        endcase
    end

    assign commit = strobe_rise && (pulse_cnt_r == pulse_target - 5'h01);

    // pulse counter, restarts on mode change, or on address change outside lock programming
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pulse_cnt_r <= '0;
        end else if (op != op_prev_r || (op != OP_PROG_LOCK && addr != addr_prev_r)) begin
            pulse_cnt_r <= '0;
        end else if (commit) begin
            pulse_cnt_r <= '0;
        end else if (strobe_rise && op inside {OP_PROG_CODE, OP_PROG_ENC, OP_PROG_LOCK}) begin
            pulse_cnt_r <= pulse_cnt_r + 5'h01;
        end
    end

    assign code_we = commit && (op == OP_PROG_CODE) && !any_lock;
    assign enc_we = commit && (op == OP_PROG_ENC) && !any_lock;
    assign lock_we = commit && (op == OP_PROG_LOCK);

    always_ff @(posedge i_ref_clk) begin
        if (code_we) begin
            code_mem_r[addr] <= i_byte_data_port;
        end
    end

    // synchronous array read of addressed byte
    always_ff @(posedge i_ref_clk) begin
        rd_code_r <= code_mem_r[addr];
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_first_lock_bit <= 1'b0;
            o_second_lock_bit <= 1'b0;
        end else if (lock_we) begin
            if (!o_first_lock_bit) begin
                o_first_lock_bit <= 1'b1;
            end else begin
                o_second_lock_bit <= 1'b1;
            end
        end
    end

    // table indexed by low six address bits
    otp_scramble_table u_table (
        .i_ref_clk(i_ref_clk),
        .i_reset_n(i_reset_n),
        .i_index(addr_prev_r[`ENC_INDEX_W-1:0]),
        .i_we(enc_we),
        .i_wdata(i_byte_data_port),
        .i_code_byte(rd_code_r),
        .o_verify_byte(verify_byte)
    );

    // selected entry seen from here, only the assertions read it
    assign entry_probe = u_table.entry_r[addr_prev_r[`ENC_INDEX_W-1:0]];

    always_comb begin
        if (op == OP_SIGNATURE) begin
            if (addr_prev_r == `SIG_MAKER_ADDR) begin
                out_nxt = SIG_MAKER_VALUE;
            end else if (addr_prev_r == `SIG_PART_ADDR) begin
                out_nxt = SIG_PART_VALUE;
            end else begin
                out_nxt = `ERASED_BYTE;
            end
        end else begin
            out_nxt = verify_byte;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_byte_data_port <= `ERASED_BYTE;
            o_byte_data_port_oe <= 1'b0;
        end else begin
            o_byte_data_port <= out_nxt;
            o_byte_data_port_oe <= read_en && read_en_r;
        end
    end

    // cycles spent reading without valid drive
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wait_cnt_r <= '0;
        end else if (read_en && !o_byte_data_port_oe) begin
            wait_cnt_r <= wait_cnt_r + 11'h001;
        end else begin
            wait_cnt_r <= '0;
        end
    end

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_n);

    verify_locked_a: assert property (o_second_lock_bit && op == OP_VERIFY |-> ##2 !o_byte_data_port_oe)
        else $error("verify data driven with second lock set");
    // data port equals scrambled array byte
    xnor_output_a: assert property (op == OP_VERIFY && $past(op) == OP_VERIFY && o_byte_data_port_oe
        |-> o_byte_data_port == ~($past(rd_code_r) ^ $past(entry_probe)))
        else $error("verify byte is not xnor of code and entry");
    enc_index_a: assert property (u_table.i_index == $past(i_address_low_port[`ENC_INDEX_W-1:0]))
        else $error("table index not from low address bits");
    access_time_a: assert property (wait_cnt_r < `ACCESS_MAX_CYC)
        else $error("read data later than access limit");
    release_port_a: assert property (!read_en |-> ##1 !o_byte_data_port_oe)
        else $error("data port not released");
    prog_no_drive_a: assert property (op inside {OP_PROG_CODE, OP_PROG_ENC, OP_PROG_LOCK}
        |=> !o_byte_data_port_oe)
        else $error("data port driven in programming mode");
    lock_blocks_a: assert property (any_lock |-> !code_we && !enc_we)
        else $error("write accepted after lock");
    code_pulses_a: assert property (code_we |-> pulse_cnt_r == `CODE_PULSES - 5'h01 && strobe_rise)
        else $error("code write not on fifth pulse");
    lock_order_a: assert property ($rose(o_second_lock_bit) |-> $past(o_first_lock_bit))
        else $error("second lock set before first");
    read_nowrite_a: assert property (read_en |-> !code_we && !enc_we && !lock_we)
        else $error("write during read mode");

    verify_read_c: cover property (op == OP_VERIFY ##2 o_byte_data_port_oe);
    code_prog_c: cover property (code_we);
    lock_prog_c: cover property ($rose(o_second_lock_bit));
    sig_read_c: cover property (op == OP_SIGNATURE && o_byte_data_port_oe);

endmodule : otp_program_verify_access

// *** test/otp_writer_model.sv ***
`timescale 1ns/1ps
`include "otp_defs.svh"

// external rom writer: drives address, mode and strobe pins, reads back data
module otp_writer_model (
    input wire logic i_ref_clk,
    input wire logic [7:0] i_data,
    input wire logic i_data_oe,
    output logic o_device_reset,
    output logic [7:0] o_address_low_port,
    output logic [6:0] o_address_high_port,
    output logic [7:0] o_write_data,
    output logic o_program_strobe_n,
    output logic o_program_store_pin,
    output otp_pkg::mode_sel_t o_mode_select,
    output logic o_supply,
    output logic o_supply_hv
);
    import otp_pkg::*;
    // setup/hold margin, 48 periods of the fastest oscillator
    localparam int SETUP_CYC = `ACCESS_MAX_CYC;
    logic drive_seen; // device drove data during a programming pulse

    // quiet pins at time zero
    initial begin
        o_device_reset = 1'b1;
        {o_address_high_port, o_address_low_port} = 15'h0000;
        o_write_data = 8'h00;
        o_program_strobe_n = 1'b1;
        o_program_store_pin = 1'b0;
        o_mode_select = mode_sel_t'(5'h00);
        o_supply = 1'b0;
        o_supply_hv = 1'b0;
        drive_seen = 1'b0;
    end

    task automatic set_pins(input logic [4:0] mode, input logic [14:0] addr, input logic sup, input logic hv);
        @(negedge i_ref_clk);
        o_mode_select = mode_sel_t'(mode);
        {o_address_high_port, o_address_low_port} = addr;
        o_supply = sup;
        o_supply_hv = hv;
    endtask : set_pins

    // pulse train with margins, one byte per call
    task automatic burn(input logic [4:0] mode, input logic [14:0] addr, input logic [7:0] data, input int pulses);
        set_pins(mode, addr, 1'b0, 1'b1);
        o_write_data = data;
        repeat (SETUP_CYC) @(negedge i_ref_clk);
        repeat (pulses) begin
            o_program_strobe_n = 1'b0;
            repeat (2) @(negedge i_ref_clk);
            if (i_data_oe !== 1'b0) drive_seen = 1'b1;
            o_program_strobe_n = 1'b1;
            repeat (2) @(negedge i_ref_clk);
        end
        repeat (SETUP_CYC) @(negedge i_ref_clk);
        set_pins(5'h00, addr, 1'b0, 1'b0);
    endtask : burn

    // program-store pin level for the next operations
    task automatic set_store(input logic lvl);
        o_program_store_pin = lvl;
    endtask : set_store

    // read one byte, bounded wait for drive and release
    task automatic fetch(input logic [4:0] mode, input logic [14:0] addr, output logic [7:0] data,
                         output logic seen, output logic released);
        set_pins(mode, addr, 1'b1, 1'b0);
        // released line shows a changed value, not the last one
        o_write_data = ~o_write_data;
        seen = 1'b0;
        for (int k = 0; k < SETUP_CYC && !seen; k++) begin
            @(negedge i_ref_clk);
            seen = (i_data_oe === 1'b1);
        end
        data = i_data;
        set_pins(5'h00, addr, 1'b0, 1'b0);
        released = 1'b0;
        for (int k = 0; k < SETUP_CYC && !released; k++) begin
            @(negedge i_ref_clk);
            released = (i_data_oe === 1'b0);
        end
    endtask : fetch
endmodule : otp_writer_model

// *** test/tb_top.sv ***
`timescale 1ns/1ps
`include "otp_defs.svh"

module tb_top;
    import otp_pkg::*;
    localparam int LIMIT = 80000; // cycle ceiling for the whole run
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic dev_reset, strobe_n, store_pin, supply, supply_hv, dut_oe, first_lock, second_lock;
    logic [7:0] addr_low, wr_data, dut_data, bus;
    logic [6:0] addr_high;
    mode_sel_t mode_sel;
    int fail_count = 0;
    int n_checks = 0;
    int cycles = 0;

    // wire level: device wins while it drives
    assign bus = dut_oe ? dut_data : wr_data;

    otp_program_verify_access otp_program_verify_access_i (.i_ref_clk(ref_clk), .i_reset_n(reset_n),
        .i_device_reset(dev_reset), .i_address_low_port(addr_low), .i_address_high_port(addr_high),
        .i_byte_data_port(bus), .o_byte_data_port(dut_data), .o_byte_data_port_oe(dut_oe),
        .i_program_strobe_n(strobe_n), .i_program_store_pin(store_pin), .i_mode_select(mode_sel),
        .i_test_enable_programming_supply(supply), .i_test_enable_programming_supply_hv(supply_hv),
        .o_first_lock_bit(first_lock), .o_second_lock_bit(second_lock));

    otp_writer_model otp_writer_model_i (.i_ref_clk(ref_clk), .i_data(bus), .i_data_oe(dut_oe),
        .o_device_reset(dev_reset), .o_address_low_port(addr_low), .o_address_high_port(addr_high),
        .o_write_data(wr_data), .o_program_strobe_n(strobe_n), .o_program_store_pin(store_pin),
        .o_mode_select(mode_sel), .o_supply(supply), .o_supply_hv(supply_hv));

    // clock generator
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end

    // compare and count
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // verdict and end of run
    task automatic results;
        if (fail_count == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : results

    // read one byte and judge timing
    task automatic rd(input logic [4:0] mode, input logic [14:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        logic seen, rel;
        otp_writer_model_i.fetch(mode, addr, d, seen, rel);
        check({7'h00, seen}, 8'h01);
        check({7'h00, rel}, 8'h01);
        check(d, exp);
    endtask : rd

    // blank byte through blank entry
    task automatic t_blank;
        rd(`MODE_VERIFY, 15'h0000, 8'hFF);
    endtask : t_blank

    // scrambled readback and entry selection
    task automatic t_scramble;
        logic [7:0] d;
        logic seen, rel;
        otp_writer_model_i.burn(`MODE_PROG_CODE, 15'h7FFF, 8'h3C, 5);
        otp_writer_model_i.burn(`MODE_PROG_ENC, 15'h003F, 8'hF0, 25);
        rd(`MODE_VERIFY, 15'h7FFF, 8'h33);
        rd(`MODE_VERIFY, 15'h003F, 8'h0F);
        rd(`MODE_VERIFY, 15'h0040, 8'hFF);
        otp_writer_model_i.fetch(`MODE_VERIFY, 15'h7FFF, d, seen, rel);
        check(d ~^ 8'hF0, 8'h3C);
        check({7'h00, otp_writer_model_i.drive_seen}, 8'h00);
    endtask : t_scramble

    // short pulse train leaves byte blank, full train writes, ff burns too
    task automatic t_pulses;
        otp_writer_model_i.burn(`MODE_PROG_CODE, 15'h0100, 8'h55, 4);
        rd(`MODE_VERIFY, 15'h0100, 8'hFF);
        otp_writer_model_i.burn(`MODE_PROG_CODE, 15'h0100, 8'h55, 5);
        rd(`MODE_VERIFY, 15'h0100, 8'hAA);
        otp_writer_model_i.burn(`MODE_PROG_CODE, 15'h1234, 8'hFF, 5);
        rd(`MODE_VERIFY, 15'h1234, 8'h00);
    endtask : t_pulses

    // signature bytes, then code unchanged
    task automatic t_signature;
        logic [7:0] d;
        logic seen, rel;
        rd(`MODE_SIGNATURE, `SIG_MAKER_ADDR, 8'hA5);
        rd(`MODE_SIGNATURE, `SIG_PART_ADDR, 8'h5A);
        rd(`MODE_SIGNATURE, 15'h003F, 8'h00);
        rd(`MODE_VERIFY, 15'h7FFF, 8'h33);
        otp_writer_model_i.set_store(1'b1);
        otp_writer_model_i.fetch(`MODE_SIGNATURE, `SIG_MAKER_ADDR, d, seen, rel);
        check({7'h00, seen}, 8'h00);
        otp_writer_model_i.set_store(1'b0);
    endtask : t_signature

    // first lock bit blocks programming, second blocks verify
    task automatic t_lock;
        logic [7:0] d;
        logic seen, rel;
        otp_writer_model_i.burn(`MODE_PROG_LOCK, 15'h0000, 8'h00, 25);
        check({6'h00, second_lock, first_lock}, 8'h01);
        otp_writer_model_i.burn(`MODE_PROG_CODE, 15'h7FFF, 8'h00, 5);
        otp_writer_model_i.burn(`MODE_PROG_ENC, 15'h003F, 8'h00, 25);
        rd(`MODE_VERIFY, 15'h7FFF, 8'h33);
        otp_writer_model_i.burn(`MODE_PROG_LOCK, 15'h0000, 8'h00, 25);
        check({6'h00, second_lock, first_lock}, 8'h03);
        otp_writer_model_i.fetch(`MODE_VERIFY, 15'h7FFF, d, seen, rel);
        check({7'h00, seen}, 8'h00);
    endtask : t_lock

    // hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            fail_count++;
            results();
        end
    end

    // main sequence
    initial begin
        repeat (12) @(negedge ref_clk);
        reset_n = 1'b1;
        t_blank();
        t_scramble();
        t_pulses();
        t_signature();
        t_lock();
        results();
    end
endmodule : tb_top
